/* inc/supervisor_pkg.sv */
/*
  shared types and constants of the supply supervisor with watchdog.
  assumes a 40 MHz system clock and comparator levels already synchronous to it.
*/
package supervisor_pkg;

  // build options: which outputs are populated
  typedef enum logic [1:0] {
    VARIANT_WDOG_RST_N,
    VARIANT_NO_WDOG,
    VARIANT_WDOG_RST
  } variant_t;

  typedef enum logic [1:0] {
    RST_HOLD,
    RST_STRETCH,
    RST_RUN
  } rst_state_t;

  // analogue comparator results, 1 = below threshold
  typedef struct packed {
    logic supply_low;
    logic monitor_low;
  } comparator_t;

  // watchdog kick pin as seen by the input stage
  typedef struct packed {
    logic level;
    logic hiz;
  } kick_t;

  localparam int CLK_PERIOD_NS    = 25;
  localparam int TICK_PERIOD_NS   = 1000000;
  localparam int TICK_CYCLES      = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_MS          = 1;
  localparam int RESET_STRETCH_MS = 200;
  localparam int STRETCH_TICKS    = RESET_STRETCH_MS / TICK_MS;
  // 1.6 s timeout
  localparam int WDOG_TIMEOUT_MS  = 1600;
  localparam int WDOG_TICKS       = WDOG_TIMEOUT_MS / TICK_MS;
  localparam int DEBOUNCE_NS      = 1000;
  localparam int DEBOUNCE_CYCLES  = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int TICK_W  = 16;
  localparam int COUNT_W = 12;
  localparam int DEB_W   = 8;

  localparam logic [TICK_W-1:0]  TICK_RESET  = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 12'h000;
  localparam logic [DEB_W-1:0]   DEB_RESET   = 8'h00;

endpackage

/* src/supply_supervisor_watchdog.sv */
/*
  digital core of a supply supervisor: reset stretcher, manual reset
  debounce, watchdog timer and power-fail output.
  assumes comparator outputs and pins arrive synchronous to clk_sys.
*/
// Summary of operation
// - a triggered reset drives the active-low reset output low for 200 ms
// - reset output stays low while the supply is below threshold
// - reset released 200 ms after supply recovery or manual reset release
// - low manual reset input triggers a reset pulse
// - manual reset input is debounced before use
// - active-high reset output is the inverse of active-low reset in the no-watchdog build
// - watchdog expires when kick input holds one level for 1.6 s
// - watchdog cleared on reset, three-stated kick, or any kick edge
// - watchdog disabled while kick input floats or is high impedance
// - timeout output goes low on expiry, stays low until timer cleared
// - timeout output also low while supply is below threshold
// - timeout output rises at once when supply recovers, no stretching
// - power-fail output low while monitor input below 1.25 V threshold
// - build option drops watchdog and adds active-high reset output
// - build option keeps watchdog, active-high reset replaces active-low
`timescale 1ns/1ps
module supply_supervisor_watchdog #(
  parameter supervisor_pkg::variant_t VARIANT         = supervisor_pkg::VARIANT_WDOG_RST_N,
  parameter int                       TICK_CYCLES_P   = supervisor_pkg::TICK_CYCLES,
  parameter int                       STRETCH_TICKS_P = supervisor_pkg::STRETCH_TICKS,
  parameter int                       WDOG_TICKS_P    = supervisor_pkg::WDOG_TICKS,
  parameter int                       DEBOUNCE_P      = supervisor_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  input  wire supervisor_pkg::comparator_t cmp,
  input  wire logic                        manual_reset_in_n,
  input  wire supervisor_pkg::kick_t       watchdog_kick_in,
  output logic                             rst_out_n,
  output logic                             rst_out,
  output logic                             watchdog_timeout_out_n,
  output logic                             power_fail_out_n
);
  import supervisor_pkg::*;

  localparam logic HAS_WDOG  = (VARIANT != VARIANT_NO_WDOG);
  localparam logic HAS_RST_N = (VARIANT != VARIANT_WDOG_RST);
  localparam logic HAS_RST   = (VARIANT != VARIANT_WDOG_RST_N);

  localparam logic [TICK_W-1:0]  TICK_LAST    = TICK_W'(TICK_CYCLES_P - 1);
  localparam logic [COUNT_W-1:0] STRETCH_LAST = COUNT_W'(STRETCH_TICKS_P - 1);
  localparam logic [COUNT_W-1:0] WDOG_LAST    = COUNT_W'(WDOG_TICKS_P - 1);
  localparam logic [DEB_W-1:0]   DEB_LAST     = DEB_W'(DEBOUNCE_P - 1);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  // time base

  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] next_tick_cnt;
  logic              tick;
  logic              next_tick;

  always_comb begin
    next_tick     = (tick_cnt == TICK_LAST);
    next_tick_cnt = next_tick ? TICK_RESET : tick_cnt + 1'b1;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= TICK_RESET;
      tick     <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick     <= next_tick;
    end
  end

  tick_period_a: assert property (tick |-> !$past(tick))
    else $error("tick pulses back to back");

  ////////////////////////////////////////////////////////////////////////////
  // manual reset debounce

  logic [DEB_W-1:0] deb_cnt;
  logic [DEB_W-1:0] next_deb_cnt;
  logic             mr_deb_n;
  logic             next_mr_deb_n;

  always_comb begin
    next_deb_cnt  = DEB_RESET;
    next_mr_deb_n = mr_deb_n;
    if (manual_reset_in_n != mr_deb_n) begin
      if (deb_cnt == DEB_LAST)
        next_mr_deb_n = manual_reset_in_n;
      else
        next_deb_cnt = deb_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      deb_cnt  <= DEB_RESET;
      mr_deb_n <= 1'b1;
    end else begin
      deb_cnt  <= next_deb_cnt;
      mr_deb_n <= next_mr_deb_n;
    end
  end

  debounce_hold_a: assert property ($changed(mr_deb_n) |-> $past(deb_cnt) == DEB_LAST)
    else $error("manual reset accepted before it was stable");

  ////////////////////////////////////////////////////////////////////////////
  // reset stretcher

  rst_state_t         state;
  rst_state_t         next_state;
  logic [COUNT_W-1:0] stretch_cnt;
  logic [COUNT_W-1:0] next_stretch_cnt;
  logic               reset_active;
  logic               next_reset_active;

  always_comb begin
    next_state       = state;
    next_stretch_cnt = stretch_cnt;
    if (cmp.supply_low || !mr_deb_n) begin
      next_state       = RST_HOLD;
      next_stretch_cnt = COUNT_RESET;
    end else begin
      unique case (state)
        RST_HOLD: begin
          next_state = RST_STRETCH;
        end
        RST_STRETCH: begin
          if (tick) begin
            if (stretch_cnt == STRETCH_LAST)
              next_state = RST_RUN;
            else
              next_stretch_cnt = stretch_cnt + 1'b1;
          end
        end
        RST_RUN: begin
          next_stretch_cnt = COUNT_RESET;
        end
      endcase
    end
    next_reset_active = (next_state != RST_RUN);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state        <= RST_HOLD;
      stretch_cnt  <= COUNT_RESET;
      reset_active <= 1'b1;
    end else begin
      state        <= next_state;
      stretch_cnt  <= next_stretch_cnt;
      reset_active <= next_reset_active;
    end
  end

  supply_hold_a: assert property (cmp.supply_low |=> reset_active && state == RST_HOLD)
    else $error("reset not held during low supply");

  manual_trigger_a: assert property (!mr_deb_n |=> reset_active)
    else $error("debounced manual reset did not assert reset");

  stretch_end_a: assert property ($rose(!reset_active) |-> $past(stretch_cnt) == STRETCH_LAST)
    else $error("reset released before full stretch");

  stretch_path_a: assert property (state == RST_RUN && $past(state) != RST_RUN |-> $past(state) == RST_STRETCH)
    else $error("reset released without stretch");

  ////////////////////////////////////////////////////////////////////////////
  // watchdog timer

  logic [COUNT_W-1:0] wd_cnt;
  logic [COUNT_W-1:0] next_wd_cnt;
  logic               wd_timeout;
  logic               next_wd_timeout;
  logic               kick_prev;
  logic               wd_clear;

  always_comb begin
    wd_clear = !HAS_WDOG || reset_active || watchdog_kick_in.hiz ||
               (watchdog_kick_in.level != kick_prev);
    next_wd_cnt     = wd_cnt;
    next_wd_timeout = wd_timeout;
    if (wd_clear) begin
      next_wd_cnt     = COUNT_RESET;
      next_wd_timeout = 1'b0;
    end else if (tick && !wd_timeout) begin
      if (wd_cnt == WDOG_LAST)
        next_wd_timeout = 1'b1;
      else
        next_wd_cnt = wd_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wd_cnt     <= COUNT_RESET;
      wd_timeout <= 1'b0;
      kick_prev  <= 1'b0;
    end else begin
      wd_cnt     <= next_wd_cnt;
      wd_timeout <= next_wd_timeout;
      kick_prev  <= watchdog_kick_in.level;
    end
  end

  wdog_expire_a: assert property (HAS_WDOG && !wd_clear && tick && wd_cnt == WDOG_LAST |=> wd_timeout)
    else $error("watchdog did not expire at full count");

  wdog_clear_a: assert property (wd_clear |=> wd_cnt == COUNT_RESET && !wd_timeout)
    else $error("watchdog not cleared");

  wdog_hiz_a: assert property (watchdog_kick_in.hiz [*2] |-> !wd_timeout && wd_cnt == COUNT_RESET)
    else $error("watchdog ran with kick input floating");

  wdog_in_reset_a: assert property (reset_active |=> wd_cnt == COUNT_RESET)
    else $error("watchdog counted during reset");

  ////////////////////////////////////////////////////////////////////////////
  // output pins, registered from next values so they change with the cause

  logic next_rst_out_n;
  logic next_rst_out;
  logic next_wdo_n;
  logic next_pfo_n;

  always_comb begin
    next_rst_out_n = HAS_RST_N ? !next_reset_active : 1'b1;
    next_rst_out   = HAS_RST ? next_reset_active : 1'b0;
    next_wdo_n     = HAS_WDOG ? !(next_wd_timeout || cmp.supply_low) : 1'b1;
    next_pfo_n     = !cmp.monitor_low;
  end

  // reset forms stay complementary even while nrst is low, in the build where both are populated
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_out_n              <= !HAS_RST_N;
      rst_out                <= HAS_RST;
      watchdog_timeout_out_n <= 1'b1;
      power_fail_out_n       <= 1'b1;
    end else begin
      rst_out_n              <= next_rst_out_n;
      rst_out                <= next_rst_out;
      watchdog_timeout_out_n <= next_wdo_n;
      power_fail_out_n       <= next_pfo_n;
    end
  end

  rst_inverse_a: assert property (HAS_RST_N && HAS_RST |-> rst_out == !rst_out_n)
    else $error("reset outputs not complementary");

  wdo_timeout_a: assert property (HAS_WDOG && wd_timeout |-> !watchdog_timeout_out_n)
    else $error("timeout output high while expired");

  wdo_lowline_a: assert property (HAS_WDOG && cmp.supply_low |=> !watchdog_timeout_out_n)
    else $error("timeout output high during low supply");

  wdo_rise_a: assert property (HAS_WDOG && $fell(cmp.supply_low) |=> watchdog_timeout_out_n)
    else $error("timeout output stretched after supply recovery");

  pfo_level_a: assert property (##1 power_fail_out_n == !$past(cmp.monitor_low))
    else $error("power-fail output does not follow monitor");

  no_wdog_a: assert property (!HAS_WDOG |-> watchdog_timeout_out_n && wd_cnt == COUNT_RESET)
    else $error("watchdog active in option without it");

  rst_high_only_a: assert property (!HAS_RST_N |-> rst_out_n && rst_out == reset_active)
    else $error("active-high reset option mis-driven");

endmodule // supply_supervisor_watchdog

/* verif/kick_model.sv */
/*
  behavioural model of the supervised processor driving the watchdog kick pin.
  assumes one clock shared with the supervisor; mode 0 kicks, 1 stalls, 2 floats.
  a floating pin settles once away from its last driven level and then stays put.
*/
`timescale 1ns/1ps
module kick_model #(
  parameter int HALF = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic [1:0]       mode,
  output supervisor_pkg::kick_t kick
);
  import supervisor_pkg::*;

  int cnt;

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      kick <= '{level: 1'b0, hiz: 1'b1};
    end else if (mode == 2'd2) begin
      // released pin: no edges while floating, so only the disable keeps the timer clear
      if (!kick.hiz) begin
        kick.level <= !kick.level;
      end
      kick.hiz <= 1'b1;
      cnt <= 0;
    end else if (mode == 2'd1) begin
      kick.hiz <= 1'b0;
      cnt <= 0;
    end else begin
      if (cnt == 0) begin
        kick <= '{level: !kick.level, hiz: 1'b0};
      end
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    end
  end
endmodule // kick_model

/* verif/tb.sv */
/*
  self-checking testbench of the supply supervisor with watchdog.
  assumes short counts: 4-cycle tick, 5-tick stretch, 10-tick timeout, 3-cycle debounce.
*/
`timescale 1ns/1ps
module tb;
  import supervisor_pkg::*;

  localparam int TK = 4;
  localparam int ST = 5;
  localparam int WD = 10;
  localparam int DB = 3;

  logic        clk_sys, nrst, manual_reset_in_n;
  comparator_t cmp;
  kick_t       kick;
  logic [1:0]  kmode;
  logic        rst_out_n, rst_out, wdo_n, pfo_n, b_rst_n, b_rst, b_wdo_n;
  logic        c_rst_n, c_rst, c_wdo_n;
  int          miscompares = 0;
  int          n_tests = 0;

  ////////////////////////////////////////////////////////////////////////////////
  supply_supervisor_watchdog #(.VARIANT(VARIANT_WDOG_RST_N), .TICK_CYCLES_P(TK), .STRETCH_TICKS_P(ST),
    .WDOG_TICKS_P(WD), .DEBOUNCE_P(DB)) uut (.clk_sys(clk_sys), .nrst(nrst), .cmp(cmp),
    .manual_reset_in_n(manual_reset_in_n), .watchdog_kick_in(kick), .rst_out_n(rst_out_n),
    .rst_out(rst_out), .watchdog_timeout_out_n(wdo_n), .power_fail_out_n(pfo_n));
  // second build without watchdog, same stimulus
  supply_supervisor_watchdog #(.VARIANT(VARIANT_NO_WDOG), .TICK_CYCLES_P(TK), .STRETCH_TICKS_P(ST),
    .WDOG_TICKS_P(WD), .DEBOUNCE_P(DB)) uut_no_wdog (.clk_sys(clk_sys), .nrst(nrst), .cmp(cmp),
    .manual_reset_in_n(manual_reset_in_n), .watchdog_kick_in(kick), .rst_out_n(b_rst_n),
    .rst_out(b_rst), .watchdog_timeout_out_n(b_wdo_n), .power_fail_out_n());
  // third build with active-high reset only, same stimulus
  supply_supervisor_watchdog #(.VARIANT(VARIANT_WDOG_RST), .TICK_CYCLES_P(TK), .STRETCH_TICKS_P(ST),
    .WDOG_TICKS_P(WD), .DEBOUNCE_P(DB)) uut_high (.clk_sys(clk_sys), .nrst(nrst), .cmp(cmp),
    .manual_reset_in_n(manual_reset_in_n), .watchdog_kick_in(kick), .rst_out_n(c_rst_n),
    .rst_out(c_rst), .watchdog_timeout_out_n(c_wdo_n), .power_fail_out_n());
  kick_model #(.HALF(8)) cpu (.clk_sys(clk_sys), .nrst(nrst), .mode(kmode), .kick(kick));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic exp, logic got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
    if (nrst) begin
      chk("variant inverse", ~b_rst_n, b_rst);
      chk("variant wdo", 1'b1, b_wdo_n);
      chk("unused high reset", 1'b0, rst_out);
      chk("high-only unused low reset", 1'b1, c_rst_n);
      chk("high-only reset", ~rst_out_n, c_rst);
      chk("high-only wdo", wdo_n, c_wdo_n);
    end
  endtask

  // counts cycles until reset releases (sel 0) or timeout falls (sel 1)
  task automatic wait_ev(bit sel, int lo, int hi);
    int k;
    k = 0;
    while ((sel ? (wdo_n === 1'b1) : (rst_out_n === 1'b0)) && k <= hi) begin
      cyc(1);
      k++;
    end
    n_tests++;
    if (k < lo || k > hi) begin
      miscompares++;
      $display("MISMATCH %s cycles expected %0d..%0d seen %0d", sel ? "timeout" : "stretch", lo, hi, k);
      if (k > hi) end_of_test();
    end
  endtask

  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_supply();
    @(posedge clk_sys);
    cmp.supply_low <= 1'b1;
    cyc(2);
    chk("rst low-line", 1'b0, rst_out_n);
    chk("wdo low-line", 1'b0, wdo_n);
    cyc(3 * ST * TK);
    chk("rst held", 1'b0, rst_out_n);
    @(posedge clk_sys);
    cmp.supply_low <= 1'b0;
    cyc(2);
    chk("wdo no stretch", 1'b1, wdo_n);
    wait_ev(0, (ST - 1) * TK - 2, ST * TK + 2);
  endtask

  task automatic t_manual();
    @(posedge clk_sys);
    manual_reset_in_n <= 1'b0;
    repeat (DB - 1) @(posedge clk_sys);
    manual_reset_in_n <= 1'b1;
    cyc(ST * TK);
    chk("short press", 1'b1, rst_out_n);
    @(posedge clk_sys);
    manual_reset_in_n <= 1'b0;
    cyc(DB + 3);
    chk("press", 1'b0, rst_out_n);
    cyc(2 * ST * TK);
    chk("press held", 1'b0, rst_out_n);
    @(posedge clk_sys);
    manual_reset_in_n <= 1'b1;
    cyc(1);
    wait_ev(0, (ST - 1) * TK, ST * TK + DB + 3);
  endtask

  task automatic t_watchdog();
    @(posedge clk_sys);
    kmode <= 2'd2;
    cyc(3 * WD * TK);
    chk("float", 1'b1, wdo_n);
    @(posedge clk_sys);
    kmode <= 2'd1;
    cyc(1);
    wait_ev(1, (WD - 1) * TK - 2, WD * TK + 3);
    cyc(20);
    chk("expired held", 1'b0, wdo_n);
    chk("no reset", 1'b1, rst_out_n);
    @(posedge clk_sys);
    kmode <= 2'd0;
    cyc(3);
    chk("kick clears", 1'b1, wdo_n);
    cyc(3 * WD * TK);
    chk("kicked", 1'b1, wdo_n);
  endtask

  // mid-run reset: outputs forced at once, then a fresh stretch
  task automatic t_reset();
    @(posedge clk_sys);
    nrst <= 1'b0;
    #1;
    chk("mid reset rst_out_n", 1'b0, rst_out_n);
    chk("mid reset inverse", 1'b1, b_rst);
    chk("mid reset high-only", 1'b1, c_rst);
    chk("mid reset unused low", 1'b1, c_rst_n);
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    cyc(1);
    chk("restart reset", 1'b0, rst_out_n);
    wait_ev(0, (ST - 1) * TK - 1, ST * TK + 2);
  endtask

  task automatic t_power_fail();
    @(posedge clk_sys);
    cmp.monitor_low <= 1'b1;
    cyc(2);
    chk("pfo low", 1'b0, pfo_n);
    @(posedge clk_sys);
    cmp.monitor_low <= 1'b0;
    cyc(2);
    chk("pfo high", 1'b1, pfo_n);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    nrst = 1'b0;
    cmp = '0;
    manual_reset_in_n = 1'b1;
    kmode = 2'd2;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    cyc(1);
    chk("power-up reset", 1'b0, rst_out_n);
    wait_ev(0, (ST - 1) * TK - 1, ST * TK + 2);
    chk("power-up wdo", 1'b1, wdo_n);
    t_power_fail();
    t_supply();
    t_manual();
    t_watchdog();
    t_reset();
    end_of_test();
  end
endmodule // tb
